// file: axst_pkg.sv
// Constants and types shared by the axis status reporting block
package axst_pkg;

   // Read command codes
   localparam logic [7:0] READ_EXTENDED_STATUS_CMD = 8'hF1;
   localparam logic [7:0] READ_INTERP_STATUS_CMD   = 8'hFF;

   // Word geometry
   localparam int WORD_W     = 32;
   localparam int AXIS_COUNT = 4;
   localparam logic [WORD_W-1:0] ZERO_WORD = 32'h00000000;

   // Extended status field positions
   localparam int EXT_STATE_LSB        = 0;
   localparam int EXT_STATE_W          = 4;
   localparam int EXT_DIR_BIT          = 4;
   localparam int EXT_START_BIT        = 5;
   localparam int EXT_STOP_BIT         = 6;
   localparam int EXT_EMERG_BIT        = 7;
   localparam int EXT_CMP_START_BIT    = 8;
   localparam int EXT_DEV_CLEAR_BIT    = 9;
   localparam int EXT_INDEX_BIT        = 10;
   localparam int EXT_PLUS_DIR_BIT     = 11;
   localparam int EXT_MINUS_DIR_BIT    = 12;
   localparam int EXT_CNT_CLEAR_BIT    = 13;
   localparam int EXT_CNT_LATCH_BIT    = 14;
   localparam int EXT_SLOWDOWN_BIT     = 15;
   localparam int EXT_IN_POS_BIT       = 16;
   localparam int EXT_CMP_FILL_LSB     = 18;
   localparam int EXT_OP_FILL_LSB      = 20;
   localparam int FILL_W               = 2;

   // Interpolation status field positions
   localparam int IP_LIN1_SET_LSB  = 0;
   localparam int IP_LIN2_SET_LSB  = 4;
   localparam int IP_CIRC_SET_LSB  = 8;
   localparam int IP_SYNTH_SET_LSB = 12;
   localparam int IP_ACTIVE_LSB    = 16;
   localparam int IP_ACTIVE_W      = 4;
   localparam int IP_CUR_QUAD_LSB  = 20;
   localparam int IP_FIN_QUAD_LSB  = 22;
   localparam int QUAD_W           = 2;
   localparam int IP_ACT_CW        = 2;
   localparam int IP_ACT_CCW       = 3;

   // Operating state codes
   localparam logic [3:0] CODE_STOPPED       = 4'h0;
   localparam logic [3:0] CODE_START_CONTROL = 4'hF;

   // Start control window length in clock cycles
   localparam logic [2:0] START_CTRL_CYCLES = 3'h4;
   localparam logic [2:0] CTR_ONE           = 3'h1;
   localparam logic [2:0] CTR_ZERO          = 3'h0;

   // Pin indexes into the synchroniser vectors
   localparam int PIN_COUNT     = 11;
   localparam int PIN_CSTART    = 0;
   localparam int PIN_ASTART    = 1;
   localparam int PIN_CSTOP     = 2;
   localparam int PIN_EMERG     = 3;
   localparam int PIN_CMP_START = 4;
   localparam int PIN_INDEX     = 5;
   localparam int PIN_PLUS_DIR  = 6;
   localparam int PIN_MINUS_DIR = 7;
   localparam int PIN_CNT_CLEAR = 8;
   localparam int PIN_CNT_LATCH = 9;
   localparam int PIN_SLOWDOWN  = 10;
   localparam logic [PIN_COUNT-1:0] PIN_RESET = 11'h7FF;

   typedef enum logic [0:0] {
      AXST_FOLLOW,
      AXST_START_CTRL
   } axst_mode_type;

   typedef struct packed {
      logic [PIN_COUNT-1:0] sync1;
      logic [PIN_COUNT-1:0] sync2;
      logic [PIN_COUNT-1:0] sync3;
      logic [PIN_COUNT-1:0] level;
      axst_mode_type        mode;
      logic [2:0]           ctr;
      logic                 rd_valid;
      logic [WORD_W-1:0]    rd_data;
   } axst_state_type;

endpackage : axst_pkg

// file: axst_status_top.sv
// Axis extended status and shared interpolation status read-out
`timescale 1ns/10ps
`default_nettype none

module axst_status_top
   import axst_pkg::*;
(
   input  wire logic                  REF_CLK,
   input  wire logic                  RST_B,
   // Read command port
   input  wire logic                  CMD_VALID,
   input  wire logic [7:0]            CMD_CODE,
   output logic                       RD_VALID,
   output logic [WORD_W-1:0]          RD_DATA,
   // Raw external pins
   input  wire logic                  COMMON_START_INPUT_N,
   input  wire logic                  AXIS_START_INPUT,
   input  wire logic                  COMMON_STOP_INPUT_N,
   input  wire logic                  EMERGENCY_STOP_INPUT_N,
   input  wire logic                  COMPARE_START_PIN,
   input  wire logic                  ENCODER_INDEX_INPUT,
   input  wire logic                  PLUS_DIRECTION_SWITCH,
   input  wire logic                  MINUS_DIRECTION_SWITCH,
   input  wire logic                  COUNTER_CLEAR_INPUT,
   input  wire logic                  COUNTER_LATCH_INPUT,
   input  wire logic                  SLOWDOWN_INPUT,
   // Polarity selections, 1 means active high
   input  wire logic                  START_PIN_POLARITY_CFG,
   input  wire logic                  CLEAR_OUTPUT_POLARITY_CFG,
   input  wire logic                  INDEX_POLARITY_CFG,
   input  wire logic                  DIRECTION_SWITCH_POLARITY_CFG,
   input  wire logic                  CLEAR_INPUT_POLARITY_CFG,
   input  wire logic                  LATCH_INPUT_POLARITY_CFG,
   input  wire logic                  SLOWDOWN_POLARITY_CFG,
   input  wire logic                  IN_POSITION_POLARITY_CFG,
   // Axis core state, same clock
   input  wire logic [EXT_STATE_W-1:0] OPERATING_STATE_CODE,
   input  wire logic                  START_CONTROL_REQ,
   input  wire logic                  MOTION_DIRECTION,
   input  wire logic                  DEVIATION_CLEAR_OUTPUT,
   input  wire logic                  IN_POSITION_LEVEL,
   input  wire logic [2:0]            COMPARE_CHAIN_DETERMINED,
   input  wire logic [2:0]            OPERATION_CHAIN_DETERMINED,
   // Interpolation core state, same clock
   input  wire logic [AXIS_COUNT-1:0] AXIS_LINEAR_ONE_SET,
   input  wire logic [AXIS_COUNT-1:0] AXIS_LINEAR_TWO_SET,
   input  wire logic [AXIS_COUNT-1:0] AXIS_CIRCULAR_SET,
   input  wire logic [AXIS_COUNT-1:0] AXIS_CONST_SYNTH_SPEED_SET,
   input  wire logic [IP_ACTIVE_W-1:0] INTERP_ACTIVE,
   input  wire logic [QUAD_W-1:0]     CURRENT_QUADRANT,
   input  wire logic [QUAD_W-1:0]     FINAL_QUADRANT
);

   // Active state of a level under a polarity selection
   function automatic logic active_of(input logic lvl, input logic active_high);
      active_of = ~(lvl ^ active_high);
   endfunction : active_of

   // Fill code rises with current, first, second register determined
   function automatic logic [FILL_W-1:0] fill_code(input logic [2:0] det);
      if (det[2] && det[1] && det[0]) begin
         fill_code = 2'h3;
      end else if (det[1] && det[0]) begin
         fill_code = 2'h2;
      end else if (det[0]) begin
         fill_code = 2'h1;
      end else begin
         fill_code = 2'h0;
      end
   endfunction : fill_code

   axst_state_type state_reg;
   axst_state_type state_next;
   logic [PIN_COUNT-1:0] raw_pins;
   logic [WORD_W-1:0]    ext_word;
   logic [WORD_W-1:0]    ip_word;
   logic [EXT_STATE_W-1:0] shown_code;

   // Gather raw pins so one loop can synchronise them all
   assign raw_pins[PIN_CSTART]    = COMMON_START_INPUT_N;
   assign raw_pins[PIN_ASTART]    = AXIS_START_INPUT;
   assign raw_pins[PIN_CSTOP]     = COMMON_STOP_INPUT_N;
   assign raw_pins[PIN_EMERG]     = EMERGENCY_STOP_INPUT_N;
   assign raw_pins[PIN_CMP_START] = COMPARE_START_PIN;
   assign raw_pins[PIN_INDEX]     = ENCODER_INDEX_INPUT;
   assign raw_pins[PIN_PLUS_DIR]  = PLUS_DIRECTION_SWITCH;
   assign raw_pins[PIN_MINUS_DIR] = MINUS_DIRECTION_SWITCH;
   assign raw_pins[PIN_CNT_CLEAR] = COUNTER_CLEAR_INPUT;
   assign raw_pins[PIN_CNT_LATCH] = COUNTER_LATCH_INPUT;
   assign raw_pins[PIN_SLOWDOWN]  = SLOWDOWN_INPUT;

   // Reported state code; the start-control window overrides the core
   assign shown_code = (state_reg.mode == AXST_START_CTRL) ? CODE_START_CONTROL
                                                           : OPERATING_STATE_CODE;

   // Extended status word built from filtered levels and core state
   always_comb begin
      ext_word = ZERO_WORD; // Unlisted bits stay zero
      ext_word[EXT_STATE_LSB +: EXT_STATE_W] = shown_code;
      ext_word[EXT_DIR_BIT]       = MOTION_DIRECTION;
      ext_word[EXT_START_BIT]     = ~state_reg.level[PIN_CSTART]
                                    | active_of(state_reg.level[PIN_ASTART], START_PIN_POLARITY_CFG);
      ext_word[EXT_STOP_BIT]      = ~state_reg.level[PIN_CSTOP];
      ext_word[EXT_EMERG_BIT]     = ~state_reg.level[PIN_EMERG];
      ext_word[EXT_CMP_START_BIT] = active_of(state_reg.level[PIN_CMP_START], START_PIN_POLARITY_CFG);
      ext_word[EXT_DEV_CLEAR_BIT] = active_of(DEVIATION_CLEAR_OUTPUT, CLEAR_OUTPUT_POLARITY_CFG);
      ext_word[EXT_INDEX_BIT]     = active_of(state_reg.level[PIN_INDEX], INDEX_POLARITY_CFG);
      // No pulser-enable gating, so the switches stay live in pulser mode
      ext_word[EXT_PLUS_DIR_BIT]  = active_of(state_reg.level[PIN_PLUS_DIR],
                                              DIRECTION_SWITCH_POLARITY_CFG);
      ext_word[EXT_MINUS_DIR_BIT] = active_of(state_reg.level[PIN_MINUS_DIR],
                                              DIRECTION_SWITCH_POLARITY_CFG);
      ext_word[EXT_CNT_CLEAR_BIT] = active_of(state_reg.level[PIN_CNT_CLEAR], CLEAR_INPUT_POLARITY_CFG);
      ext_word[EXT_CNT_LATCH_BIT] = active_of(state_reg.level[PIN_CNT_LATCH], LATCH_INPUT_POLARITY_CFG);
      ext_word[EXT_SLOWDOWN_BIT]  = active_of(state_reg.level[PIN_SLOWDOWN], SLOWDOWN_POLARITY_CFG);
      ext_word[EXT_IN_POS_BIT]    = active_of(IN_POSITION_LEVEL, IN_POSITION_POLARITY_CFG);
      ext_word[EXT_CMP_FILL_LSB +: FILL_W] = fill_code(COMPARE_CHAIN_DETERMINED);
      ext_word[EXT_OP_FILL_LSB +: FILL_W]  = fill_code(OPERATION_CHAIN_DETERMINED);
   end

   // Interpolation status word, identical for every axis selection
   always_comb begin
      ip_word = ZERO_WORD; // Top byte stays zero
      ip_word[IP_LIN1_SET_LSB +: AXIS_COUNT]  = AXIS_LINEAR_ONE_SET;
      ip_word[IP_LIN2_SET_LSB +: AXIS_COUNT]  = AXIS_LINEAR_TWO_SET;
      ip_word[IP_CIRC_SET_LSB +: AXIS_COUNT]  = AXIS_CIRCULAR_SET;
      ip_word[IP_SYNTH_SET_LSB +: AXIS_COUNT] = AXIS_CONST_SYNTH_SPEED_SET;
      ip_word[IP_ACTIVE_LSB +: IP_ACTIVE_W]   = INTERP_ACTIVE;
      // Quadrants only mean something while an arc runs
      if (INTERP_ACTIVE[IP_ACT_CW] || INTERP_ACTIVE[IP_ACT_CCW]) begin
         ip_word[IP_CUR_QUAD_LSB +: QUAD_W] = CURRENT_QUADRANT;
         ip_word[IP_FIN_QUAD_LSB +: QUAD_W] = FINAL_QUADRANT;
      end
   end

   // Next-state logic for synchronisers, start window and read answer
   always_comb begin
      state_next = state_reg;
      // Three-stage pipe; stage one feeds only stage two
      state_next.sync1 = raw_pins;
      state_next.sync2 = state_reg.sync1;
      state_next.sync3 = state_reg.sync2;
      for (int i = 0; i < PIN_COUNT; i++) begin
         // A change counts only once stages two and three agree
         if (state_reg.sync2[i] == state_reg.sync3[i]) begin
            state_next.level[i] = state_reg.sync3[i];
         end
      end
      // Start-control window always times out on its own
      unique case (state_reg.mode)
         AXST_FOLLOW: begin
            if (START_CONTROL_REQ) begin
               state_next.mode = AXST_START_CTRL;
               state_next.ctr  = START_CTRL_CYCLES - CTR_ONE;
            end
         end
         AXST_START_CTRL: begin
            if (state_reg.ctr == CTR_ZERO) begin
               state_next.mode = AXST_FOLLOW;
            end else begin
               state_next.ctr = state_reg.ctr - CTR_ONE;
            end
         end
      endcase
      // Reads only copy a word out; nothing inside is disturbed
      state_next.rd_valid = 1'b0;
      if (CMD_VALID) begin
         if (CMD_CODE == READ_EXTENDED_STATUS_CMD) begin
            state_next.rd_valid = 1'b1;
            state_next.rd_data  = ext_word;
         end else if (CMD_CODE == READ_INTERP_STATUS_CMD) begin
            state_next.rd_valid = 1'b1;
            state_next.rd_data  = ip_word;
         end
      end
   end

   // State register; pins reset high, the inactive level of the common start, common stop and emergency pins
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_reg.sync1    <= PIN_RESET;
         state_reg.sync2    <= PIN_RESET;
         state_reg.sync3    <= PIN_RESET;
         state_reg.level    <= PIN_RESET;
         state_reg.mode     <= AXST_FOLLOW;
         state_reg.ctr      <= CTR_ZERO;
         state_reg.rd_valid <= 1'b0;
         state_reg.rd_data  <= ZERO_WORD;
      end else begin
         state_reg <= state_next;
      end
   end

   assign RD_VALID = state_reg.rd_valid;
   assign RD_DATA  = state_reg.rd_data;

endmodule : axst_status_top

`default_nettype wire

// file: axst_status_top_asserts.sv
// Checker for the axis status read port
`timescale 1ns/10ps
`default_nettype none
module axst_status_top_asserts
   import axst_pkg::*;
(
   input wire logic                   REF_CLK,
   input wire logic                   RST_B,
   input wire logic                   CMD_VALID,
   input wire logic [7:0]             CMD_CODE,
   input wire logic                   RD_VALID,
   input wire logic [WORD_W-1:0]      RD_DATA,
   input wire logic                   MOTION_DIRECTION,
   input wire logic                   DEVIATION_CLEAR_OUTPUT,
   input wire logic                   CLEAR_OUTPUT_POLARITY_CFG,
   input wire logic [IP_ACTIVE_W-1:0] INTERP_ACTIVE,
   input wire logic [AXIS_COUNT-1:0]  AXIS_LINEAR_ONE_SET
);
   logic ext_cmd;
   logic ip_cmd;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   // Accepted read requests, one per word
   assign ext_cmd = CMD_VALID && (CMD_CODE == READ_EXTENDED_STATUS_CMD);
   assign ip_cmd  = CMD_VALID && (CMD_CODE == READ_INTERP_STATUS_CMD);
   property p_answer; ext_cmd || ip_cmd |=> RD_VALID; endproperty
   a_answer: assert property (p_answer) else $error("read not answered next cycle");
   property p_refuse; !(ext_cmd || ip_cmd) |=> !RD_VALID && $stable(RD_DATA); endproperty
   a_refuse: assert property (p_refuse) else $error("answer without accepted read");
   property p_ext_zero; ext_cmd |=> RD_DATA[31:22] == 10'h000 && !RD_DATA[17]; endproperty
   a_ext_zero: assert property (p_ext_zero) else $error("extended reserved bits set");
   property p_ip_zero; ip_cmd |=> RD_DATA[31:24] == 8'h00; endproperty
   a_ip_zero: assert property (p_ip_zero) else $error("interp reserved bits set");
   property p_dir; ext_cmd |=> RD_DATA[EXT_DIR_BIT] == $past(MOTION_DIRECTION); endproperty
   a_dir: assert property (p_dir) else $error("direction bit wrong");
   property p_clear; ext_cmd |=> RD_DATA[9] == ($past(DEVIATION_CLEAR_OUTPUT) ~^ $past(CLEAR_OUTPUT_POLARITY_CFG)); endproperty
   a_clear: assert property (p_clear) else $error("clear output flag wrong");
   property p_active; ip_cmd |=> RD_DATA[19:16] == $past(INTERP_ACTIVE); endproperty
   a_active: assert property (p_active) else $error("interp progress bits wrong");
   property p_lin1; ip_cmd |=> RD_DATA[3:0] == $past(AXIS_LINEAR_ONE_SET); endproperty
   a_lin1: assert property (p_lin1) else $error("linear one set bits wrong");
   // Quadrants only mean something in circular motion, so they must read zero otherwise
   property p_quad; ip_cmd && INTERP_ACTIVE[3:2] == 2'h0 |=> RD_DATA[23:20] == 4'h0; endproperty
   a_quad: assert property (p_quad) else $error("quadrant shown outside circle");
endmodule : axst_status_top_asserts
bind axst_status_top axst_status_top_asserts u_chk (.REF_CLK, .RST_B, .CMD_VALID, .CMD_CODE, .RD_VALID,
   .RD_DATA, .MOTION_DIRECTION, .DEVIATION_CLEAR_OUTPUT, .CLEAR_OUTPUT_POLARITY_CFG, .INTERP_ACTIVE,
   .AXIS_LINEAR_ONE_SET);
`default_nettype wire

// file: axst_host_model.sv
// Host processor model issuing status read commands
`timescale 1ns/10ps
`default_nettype none
module axst_host_model
   import axst_pkg::*;
(
   input  wire logic              REF_CLK,
   output logic                   CMD_VALID,
   output logic [7:0]             CMD_CODE,
   input  wire logic              RD_VALID,
   input  wire logic [WORD_W-1:0] RD_DATA
);
   initial begin
      CMD_VALID = 1'b0;
      CMD_CODE = 8'h00;
   end
   // One strobe per read; idle code is inverted so a stale code is never mistaken for a new one
   task automatic issue(input logic [7:0] code, output logic got, output logic [WORD_W-1:0] word);
      int n;
      got = 1'b0;
      word = ZERO_WORD;
      CMD_VALID = 1'b1;
      CMD_CODE = code;
      @(posedge REF_CLK);
      #1;
      CMD_VALID = 1'b0;
      CMD_CODE = ~code;
      for (n = 0; n < 3 && !got; n++) begin
         if (RD_VALID === 1'b1) begin
            got = 1'b1;
            word = RD_DATA;
         end
         @(posedge REF_CLK);
         #1;
      end
   endtask : issue
endmodule : axst_host_model
`default_nettype wire

// file: axst_status_top_tb.sv
// Self-checking bench for the axis status read-out
`timescale 1ns/10ps
`default_nettype none
module axst_status_top_tb
   import axst_pkg::*;
;
   logic ref_clk, rst_b, areq, dir, devclr, inpos, cmd_valid, rd_valid, g;
   logic [10:0] pin;
   logic [7:0]  cfg, cmd_code;
   logic [3:0]  code, act;
   logic [2:0]  cdet, odet;
   logic [15:0] sets;
   logic [1:0]  cq, fq;
   logic [31:0] rd_data, w;
   int          errors, checks, cyc, i;
   axst_status_top u_dut (.REF_CLK(ref_clk), .RST_B(rst_b), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
      .RD_VALID(rd_valid), .RD_DATA(rd_data), .COMMON_START_INPUT_N(pin[0]), .AXIS_START_INPUT(pin[1]),
      .COMMON_STOP_INPUT_N(pin[2]), .EMERGENCY_STOP_INPUT_N(pin[3]), .COMPARE_START_PIN(pin[4]),
      .ENCODER_INDEX_INPUT(pin[5]), .PLUS_DIRECTION_SWITCH(pin[6]), .MINUS_DIRECTION_SWITCH(pin[7]),
      .COUNTER_CLEAR_INPUT(pin[8]), .COUNTER_LATCH_INPUT(pin[9]), .SLOWDOWN_INPUT(pin[10]),
      .START_PIN_POLARITY_CFG(cfg[0]), .CLEAR_OUTPUT_POLARITY_CFG(cfg[1]), .INDEX_POLARITY_CFG(cfg[2]),
      .DIRECTION_SWITCH_POLARITY_CFG(cfg[3]), .CLEAR_INPUT_POLARITY_CFG(cfg[4]),
      .LATCH_INPUT_POLARITY_CFG(cfg[5]), .SLOWDOWN_POLARITY_CFG(cfg[6]), .IN_POSITION_POLARITY_CFG(cfg[7]),
      .OPERATING_STATE_CODE(code), .START_CONTROL_REQ(areq), .MOTION_DIRECTION(dir),
      .DEVIATION_CLEAR_OUTPUT(devclr), .IN_POSITION_LEVEL(inpos), .COMPARE_CHAIN_DETERMINED(cdet),
      .OPERATION_CHAIN_DETERMINED(odet), .AXIS_LINEAR_ONE_SET(sets[3:0]), .AXIS_LINEAR_TWO_SET(sets[7:4]),
      .AXIS_CIRCULAR_SET(sets[11:8]), .AXIS_CONST_SYNTH_SPEED_SET(sets[15:12]), .INTERP_ACTIVE(act),
      .CURRENT_QUADRANT(cq), .FINAL_QUADRANT(fq));
   axst_host_model u_host (.REF_CLK(ref_clk), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
      .RD_VALID(rd_valid), .RD_DATA(rd_data));
   function automatic logic [1:0] fill(input logic [2:0] d);
      fill = d[0] ? (d[1] ? (d[2] ? 2'h3 : 2'h2) : 2'h1) : 2'h0;
   endfunction : fill
   // Expected words built from what the bench drives
   function automatic logic [31:0] ext_exp();
      ext_exp = {10'h000, fill(odet), fill(cdet), 1'b0, inpos ~^ cfg[7], pin[10] ~^ cfg[6], pin[9] ~^ cfg[5],
         pin[8] ~^ cfg[4], pin[7] ~^ cfg[3], pin[6] ~^ cfg[3], pin[5] ~^ cfg[2], devclr ~^ cfg[1],
         pin[4] ~^ cfg[0], ~pin[3], ~pin[2], ~pin[0] | (pin[1] ~^ cfg[0]), dir, code};
   endfunction : ext_exp
   function automatic logic [31:0] ip_exp();
      ip_exp = {8'h00, (act[2] | act[3]) ? {fq, cq} : 4'h0, act, sets};
   endfunction : ip_exp
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic rd(input logic [7:0] c, input logic [31:0] e);
      u_host.issue(c, g, w);
      check({31'h0, g}, 32'h1);
      check(w, e);
   endtask : rd
   task automatic complete_run();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run
   always #2.5 ref_clk = ~ref_clk;
   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         $display("mismatch at %0t: timeout", $time);
         complete_run();
      end
   end
   initial begin
      {ref_clk, rst_b, areq, dir, devclr, inpos, code, act, cdet, odet, sets, cq, fq} = '0;
      pin = 11'h7FF;
      cfg = 8'hFF;
      repeat (12) @(posedge ref_clk);
      #1;
      check({31'h0, rd_valid}, 32'h0);
      check(rd_data, 32'h0);
      $display("reset test done");
      rst_b = 1'b1;
      // Sweep pins, polarities and core fields; pins need four edges to pass the filter
      for (i = 0; i < 16; i++) begin
         code = i[3:0];
         {dir, devclr, inpos} = i[2:0];
         pin = 11'h2B5 ^ {i[2:0], i[3:0], i[3:0]};
         cfg = 8'h96 ^ {i[3:0], i[3:0]};
         cdet = i[2:0];
         odet = ~i[2:0];
         repeat (6) @(posedge ref_clk);
         #1;
         rd(READ_EXTENDED_STATUS_CMD, ext_exp());
      end
      $display("extended word test done");
      // Shared word, then the other word straight after
      for (i = 0; i < 16; i++) begin
         sets = {i[3:0], ~i[3:0], i[3:0] ^ 4'h5, 4'h1 << i[1:0]};
         act = i[3:0];
         {fq, cq} = ~i[3:0];
         rd(READ_INTERP_STATUS_CMD, ip_exp());
         rd(READ_EXTENDED_STATUS_CMD, ext_exp());
      end
      $display("interpolation word test done");
      u_host.issue(8'hF2, g, w);
      check({31'h0, g}, 32'h0);
      check(rd_data, ext_exp());
      $display("unknown command test done");
      code = 4'h3;
      areq = 1'b1;
      @(posedge ref_clk);
      #1;
      areq = 1'b0;
      rd(READ_EXTENDED_STATUS_CMD, ext_exp() | 32'hF);
      repeat (4) @(posedge ref_clk);
      #1;
      rd(READ_EXTENDED_STATUS_CMD, ext_exp());
      $display("start control test done");
      complete_run();
   end
endmodule : axst_status_top_tb
`default_nettype wire
